/* File: mosc_pkg.sv */
/*
  Shared constants and carrier types for the main oscillator startup
  timer and main clock frequency meter.
  Assumes one 100 MHz reference clock; every other clock is sampled.
*/
// Operation
// - oscillator off, slow clock selected after reset
// - provide slow, main and pll clocks
// - disabling oscillator clears stable flag immediately
// - enable write clears stable, starts divided countdown
// - startup count field is eight bits wide
// - countdown reaching zero sets stable flag
// - masked stable flag raises interrupt request
// - meter counts main cycles after slow rise
// - sixteenth slow fall stops meter, sets ready
// - frozen main cycle count readable as result
// - control and status sit in power controller
package mosc_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int MOSC_COUNT_W = 8; // startup count field width
  localparam int MOSC_FREQ_W = 16; // measured frequency field width
  localparam int MOSC_DIV_W = 3; // prescaler width for slow / 8
  localparam logic [2:0] MOSC_SLOW_DIV_LAST = 3'h7; // 8 slow rises a tick
  localparam logic [4:0] MOSC_MEAS_LAST = 5'h0f; // 16th slow fall
  localparam int MOSC_MAX_STARTUP_MS = 62; // longest startup, ms

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MOSC_COUNT_RST = 8'h00;
  localparam logic [15:0] MOSC_FREQ_RST = 16'h0000;

  // ----------------------------------------------------------------
  // state encodings (gray along the usual path)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MOSC_OFF = 2'b00,
    MOSC_STARTUP = 2'b01,
    MOSC_STABLE = 2'b11
  } mosc_osc_state_e;

  typedef enum logic [1:0] {
    MOSC_M_WAIT = 2'b00,
    MOSC_M_COUNT = 2'b01,
    MOSC_M_DONE = 2'b11
  } mosc_meas_state_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // one write to the oscillator control register
  typedef struct packed {
    logic enable;
    logic [7:0] count;
  } mosc_ctrl_wr_s;

  // status word as software reads it
  typedef struct packed {
    logic stable;
    logic freq_ready;
    logic [15:0] freq_count;
  } mosc_status_s;

endpackage

/* File: mosc_edge.sv */
/*
  Two-flop synchroniser with rise and fall detection for a sampled
  clock input.
  Assumes the input toggles slower than half the reference clock.
*/
`timescale 1ns/100ps
module mosc_edge
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta; // first stage, read only by the second
  logic sync; // second stage
  logic last; // previous synced value for edge detection

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  // sampled clocks are foreign to ref_clk, so resync first
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign level = sync;
  assign rise = sync & ~last;
  assign fall = ~sync & last;

endmodule

/* File: mosc_ctrl.sv */
/*
  Main oscillator control: enable, startup countdown on slow clock / 8,
  stable flag with maskable interrupt, and main clock frequency meter
  from a slow clock rise to the 16th slow clock fall.
  Assumes slow_clock, main_clock and pll_clock arrive as plain levels
  and that main_clock runs below half of ref_clk; the power controller
  register file drives ctrl_wr and reads status.
*/
`timescale 1ns/100ps
module mosc_ctrl
#(
  parameter int FREQ_W = mosc_pkg::MOSC_FREQ_W
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow_clock, // always-on rc clock, sampled
  input wire logic main_clock, // main oscillator output, sampled
  input wire logic pll_clock, // pll output, sampled
  input wire logic ctrl_wr, // one-cycle write strobe
  input wire mosc_pkg::mosc_ctrl_wr_s ctrl_wr_data, // write payload
  input wire logic irq_mask, // stable flag interrupt mask bit
  input wire logic main_clock_request, // software asks for main clock
  output logic main_osc_enable, // drives analog oscillator enable
  output mosc_pkg::mosc_status_s status, // status word
  output logic osc_irq, // interrupt request, active high
  output logic clk_sel_main, // 1 = main clock selected
  output logic slow_clock_out, // resynced slow clock
  output logic main_clock_out, // resynced main clock, gated
  output logic pll_clock_out // resynced pll clock
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic slow_lvl; // synced slow clock level
  logic slow_rise; // slow clock rising edge
  logic slow_fall; // slow clock falling edge
  logic main_lvl; // synced main clock level
  logic main_rise; // main clock rising edge
  logic pll_lvl; // synced pll clock level
  mosc_pkg::mosc_osc_state_e osc_state; // oscillator state
  mosc_pkg::mosc_meas_state_e meas_state; // meter state
  logic [7:0] startup_cnt; // startup down-counter
  logic [2:0] prescale; // slow / 8 prescaler
  logic div_tick; // one tick every 8 slow rises
  logic [4:0] fall_cnt; // slow falls seen while measuring
  logic [FREQ_W-1:0] freq_cnt; // main cycles counted
  logic stable; // oscillator stable flag
  logic freq_ready; // measurement done flag
  logic wr_on; // write enabling the oscillator
  logic wr_off; // write disabling the oscillator

  assign wr_on = ctrl_wr & ctrl_wr_data.enable;
  assign wr_off = ctrl_wr & ~ctrl_wr_data.enable;

  // ----------------------------------------------------------------
  // clock input synchronisers
  // ----------------------------------------------------------------
  mosc_edge u_slow
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(slow_clock),
    .level(slow_lvl),
    .rise(slow_rise),
    .fall(slow_fall)
  );

  mosc_edge u_main
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(main_clock),
    .level(main_lvl),
    .rise(main_rise),
    .fall()
  );

  mosc_edge u_pll
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(pll_clock),
    .level(pll_lvl),
    .rise(),
    .fall()
  );

  // ----------------------------------------------------------------
  // clock outputs and selection
  // ----------------------------------------------------------------
  // main clock is forwarded only once stable so no runt cycles escape
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      slow_clock_out <= 1'b0;
      main_clock_out <= 1'b0;
      pll_clock_out <= 1'b0;
      clk_sel_main <= 1'b0;
    end
    else
    begin
      slow_clock_out <= slow_lvl;
      main_clock_out <= main_lvl & stable;
      pll_clock_out <= pll_lvl;
      clk_sel_main <= main_clock_request & stable & ~wr_off;
    end
  end

  // ----------------------------------------------------------------
  // slow clock / 8 prescaler
  // ----------------------------------------------------------------
  // restarts on each enabling write so the first tick is a full 8
  always_ff @(posedge ref_clk)
  begin
    if (reset || wr_on || osc_state != mosc_pkg::MOSC_STARTUP)
    begin
      prescale <= 3'h0;
    end
    else if (slow_rise)
    begin
      prescale <= prescale + 3'h1;
    end
  end

  assign div_tick = slow_rise && (prescale == mosc_pkg::MOSC_SLOW_DIV_LAST);

  // ----------------------------------------------------------------
  // oscillator enable and startup countdown
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      osc_state <= mosc_pkg::MOSC_OFF;
      main_osc_enable <= 1'b0;
      startup_cnt <= mosc_pkg::MOSC_COUNT_RST;
      stable <= 1'b0;
    end
    else if (wr_off)
    begin
      // disabling always wins: oscillator down, flag cleared now
      osc_state <= mosc_pkg::MOSC_OFF;
      main_osc_enable <= 1'b0;
      stable <= 1'b0;
    end
    else if (wr_on)
    begin
      // a fresh enable restarts timing even if already stable
      osc_state <= mosc_pkg::MOSC_STARTUP;
      main_osc_enable <= 1'b1;
      startup_cnt <= ctrl_wr_data.count;
      stable <= 1'b0;
    end
    else
    begin
      unique case (osc_state)
        mosc_pkg::MOSC_OFF:
        begin
          stable <= 1'b0;
        end
        mosc_pkg::MOSC_STARTUP:
        begin
          // a zero count is stable on the very next cycle
          if (startup_cnt == 8'h00)
          begin
            osc_state <= mosc_pkg::MOSC_STABLE;
            stable <= 1'b1;
          end
          else if (div_tick)
          begin
            startup_cnt <= startup_cnt - 8'h01;
          end
        end
        mosc_pkg::MOSC_STABLE:
        begin
          stable <= 1'b1;
        end
        default:
        begin
          osc_state <= mosc_pkg::MOSC_OFF;
          stable <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // registered so the request never glitches on mask writes
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      osc_irq <= 1'b0;
    end
    else
    begin
      osc_irq <= stable & irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // main clock frequency meter
  // ----------------------------------------------------------------
  // limitation: main edges are sampled, so main_clock must stay below
  // half of ref_clk for the count to be exact
  always_ff @(posedge ref_clk)
  begin
    if (reset || !stable || ctrl_wr)
    begin
      meas_state <= mosc_pkg::MOSC_M_WAIT;
      fall_cnt <= 5'h00;
      freq_cnt <= '0;
      freq_ready <= 1'b0;
    end
    else
    begin
      unique case (meas_state)
        mosc_pkg::MOSC_M_WAIT:
        begin
          if (slow_rise)
          begin
            meas_state <= mosc_pkg::MOSC_M_COUNT;
          end
        end
        mosc_pkg::MOSC_M_COUNT:
        begin
          if (main_rise && freq_cnt != '1)
          begin
            freq_cnt <= freq_cnt + FREQ_W'(1);
          end
          if (slow_fall)
          begin
            if (fall_cnt == mosc_pkg::MOSC_MEAS_LAST)
            begin
              meas_state <= mosc_pkg::MOSC_M_DONE;
              freq_ready <= 1'b1;
            end
            else
            begin
              fall_cnt <= fall_cnt + 5'h01;
            end
          end
        end
        mosc_pkg::MOSC_M_DONE:
        begin
          freq_ready <= 1'b1; // count frozen
        end
        default:
        begin
          meas_state <= mosc_pkg::MOSC_M_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status word towards the power controller register file
  // ----------------------------------------------------------------
  assign status.stable = stable;
  assign status.freq_ready = freq_ready;
  assign status.freq_count = 16'(freq_cnt);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_RESET_OFF: assert property (
    $fell(reset) |-> !main_osc_enable && !clk_sel_main && !stable)
    else $error("oscillator not off after reset");

  AST_DISABLE_CLEARS: assert property (
    wr_off |=> !stable && !main_osc_enable && !freq_ready)
    else $error("disable write did not clear stable");

  AST_ENABLE_LOADS: assert property (
    wr_on |=> !stable && main_osc_enable
      && startup_cnt == $past(ctrl_wr_data.count))
    else $error("enable write did not load countdown");

  AST_HOLD_NO_TICK: assert property (
    osc_state == mosc_pkg::MOSC_STARTUP && !div_tick && !ctrl_wr
      |=> startup_cnt == $past(startup_cnt))
    else $error("countdown moved without divided tick");

  AST_STABLE_AT_ZERO: assert property (
    osc_state == mosc_pkg::MOSC_STARTUP && startup_cnt == 8'h00
      && !ctrl_wr |=> stable)
    else $error("stable not set at zero count");

  AST_NOT_STABLE_EARLY: assert property (
    $rose(stable) |-> $past(startup_cnt) == 8'h00)
    else $error("stable set before countdown ended");

  AST_IRQ_FOLLOWS: assert property (
    stable && irq_mask && !ctrl_wr |=> osc_irq)
    else $error("masked stable flag gave no interrupt");

  AST_READY_16: assert property (
    $rose(freq_ready) |-> $past(slow_fall)
      && $past(fall_cnt) == 5'h0f)
    else $error("ready not on sixteenth slow fall");

  AST_FROZEN: assert property (
    freq_ready && !ctrl_wr |=> $stable(status.freq_count))
    else $error("measured count changed after ready");

  AST_SEL_NEEDS_STABLE: assert property (
    clk_sel_main |-> $past(stable))
    else $error("main clock selected while not stable");

  COV_STABLE: cover property ($rose(stable));
  COV_READY: cover property ($rose(freq_ready));
  COV_ABORT: cover property (
    meas_state == mosc_pkg::MOSC_M_COUNT && wr_off);
  COV_REENABLE: cover property (stable && wr_on);

endmodule

/* File: test_mosc_ctrl.sv */
/*
  Self-checking bench for the main oscillator control block: startup
  countdown, stable flag, interrupt, clock select and frequency meter.
  Assumes the package and design files are compiled first; the slow,
  main and pll clocks are plain toggles made here, and the main clock
  only runs while the block powers the oscillator.
*/
`timescale 1ns/100ps
module test_mosc_ctrl;

  // ----------------------------------------------------------------
  // stimulus clocks and expectations
  // ----------------------------------------------------------------
  localparam int SLOW_HALF = 200; // slow period 40 ref cycles
  localparam int MAIN_HALF = 40; // main period 8 ref cycles
  localparam int FREQ_EXP = 16 * SLOW_HALF / MAIN_HALF; // 16 periods
  localparam int K_EN = 0; // note kinds, one per observed output or group of outputs
  localparam int K_ST = 1;
  localparam int K_RDY = 2;
  localparam int K_IRQ = 3;
  localparam int K_SEL = 4;
  localparam int K_FRQ = 5;
  localparam int K_ALL = 6;
  localparam int K_MCK = 7;
  localparam int K_CKO = 8;

  typedef struct {
    int kind;
    logic [20:0] val;
  } mosc_note_s;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic slow_clock = 1'b0;
  logic main_clock = 1'b0;
  logic pll_clock = 1'b0;
  logic ctrl_wr = 1'b0;
  mosc_pkg::mosc_ctrl_wr_s ctrl_wr_data = '0;
  logic irq_mask = 1'b0;
  logic main_clock_request = 1'b0;
  logic main_osc_enable;
  mosc_pkg::mosc_status_s status;
  logic osc_irq;
  logic clk_sel_main;
  logic main_clock_out;
  logic slow_clock_out;
  logic pll_clock_out;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] lfsr = 8'h55; // random source, fixed start
  mosc_note_s notes[$]; // expected results, oldest first
  mosc_note_s cur;
  event look;

  mosc_ctrl mosc_ctrl_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .slow_clock(slow_clock),
    .main_clock(main_clock),
    .pll_clock(pll_clock),
    .ctrl_wr(ctrl_wr),
    .ctrl_wr_data(ctrl_wr_data),
    .irq_mask(irq_mask),
    .main_clock_request(main_clock_request),
    .main_osc_enable(main_osc_enable),
    .status(status),
    .osc_irq(osc_irq),
    .clk_sel_main(clk_sel_main),
    .slow_clock_out(slow_clock_out),
    .main_clock_out(main_clock_out),
    .pll_clock_out(pll_clock_out)
  );

  // ----------------------------------------------------------------
  // clocks; side clocks move on falling ref edges, away from sampling
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  always #SLOW_HALF slow_clock = ~slow_clock;
  // a powered-down crystal gives no edges, so the meter sees none
  always #MAIN_HALF main_clock = main_osc_enable & ~main_clock;
  always #30 pll_clock = ~pll_clock;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input string what, input logic [20:0] seen,
                       input logic [20:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // inputs always change one ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic note(input int kind, input logic [20:0] val);
    mosc_note_s n;
    n.kind = kind;
    n.val = val;
    notes.push_back(n);
    -> look;
  endtask

  // enable and count always travel in the same word
  task automatic write(input logic en, input logic [7:0] cnt);
    ctrl_wr = 1'b1;
    ctrl_wr_data.enable = en;
    ctrl_wr_data.count = cnt;
    tick(1);
    ctrl_wr = 1'b0;
  endtask

  // bounded wait on stable (rdy low) or on meter ready (rdy high)
  task automatic wait_for(input logic rdy, input int bound);
    int i;
    for (i = 0; i < bound; i++)
    begin
      if (rdy ? status.freq_ready === 1'b1 : status.stable === 1'b1)
        break;
      tick(1);
    end
    if (i == bound)
    begin
      check("wait_timeout", 21'h1, 21'h0);
      wrap_up();
    end
  endtask

  // countdown of n ticks of slow / 8; first slow rise may come at once
  task automatic startup(input logic [7:0] n);
    write(1'b1, n);
    note(K_EN, 21'h1);
    note(K_ST, 21'h0);
    tick(40 * (8 * int'(n) - 1) - 1);
    note(K_ST, 21'h0);
    wait_for(1'b0, 80);
    note(K_ST, 21'h1);
  endtask

  // resynced clock outputs show the pins two edges after capture;
  // only called while stable, so the main clock is not gated off
  task automatic clocks_follow();
    logic [2:0] pins;
    pins = {slow_clock, main_clock, pll_clock};
    tick(2);
    note(K_CKO, 21'(pins));
  endtask

  // ----------------------------------------------------------------
  // monitor: takes the oldest note and compares it with the outputs
  // ----------------------------------------------------------------
  always @(look)
  begin
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      case (cur.kind)
        K_EN: check("main_osc_enable", 21'(main_osc_enable), cur.val);
        K_ST: check("stable", 21'(status.stable), cur.val);
        K_RDY: check("freq_ready", 21'(status.freq_ready), cur.val);
        K_IRQ: check("osc_irq", 21'(osc_irq), cur.val);
        K_SEL: check("clk_sel_main", 21'(clk_sel_main), cur.val);
        K_FRQ: check("freq_count_in_range",
                     21'(status.freq_count >= FREQ_EXP - 4 &&
                         status.freq_count <= FREQ_EXP + 1), cur.val);
        K_MCK: check("main_clock_out", 21'(main_clock_out), cur.val);
        K_CKO: check("clock_outputs",
                     21'({slow_clock_out, main_clock_out, pll_clock_out}),
                     cur.val);
        default: check("outputs",
                       {status, main_osc_enable, osc_irq, clk_sel_main},
                       cur.val);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(4);
    reset = 1'b0;
    tick(1);
    note(K_ALL, 21'h0);
    irq_mask = 1'b1;
    main_clock_request = 1'b1;
    tick(1);
    note(K_SEL, 21'h0);
    startup(8'h1 + {6'h0, lfsr[1:0]});
    lfsr = lfsr_next(lfsr);
    note(K_RDY, 21'h0);
    tick(2);
    note(K_IRQ, 21'h1);
    note(K_SEL, 21'h1);
    wait_for(1'b1, 800);
    note(K_FRQ, 21'h1);
    // main clock keeps running; a live counter would leave the range
    tick(200);
    note(K_FRQ, 21'h1);
    note(K_RDY, 21'h1);
    clocks_follow();
    irq_mask = 1'b0;
    tick(2);
    note(K_IRQ, 21'h0);
    // enabling write while stable restarts the countdown
    startup(8'h1 + {6'h0, lfsr[1:0]});
    lfsr = lfsr_next(lfsr);
    wait_for(1'b1, 800);
    // disable after a full measurement drops every flag at once
    write(1'b0, lfsr);
    note(K_EN, 21'h0);
    note(K_ST, 21'h0);
    note(K_RDY, 21'h0);
    tick(10);
    note(K_MCK, 21'h0);
    note(K_SEL, 21'h0);
    // count zero: stable one cycle after the enable lands
    write(1'b1, 8'h00);
    note(K_ST, 21'h0);
    tick(1);
    note(K_ST, 21'h1);
    // back to back writes, the disabling one last, so it wins
    ctrl_wr = 1'b1;
    ctrl_wr_data = {1'b1, 8'h00};
    tick(1);
    ctrl_wr_data = {1'b0, lfsr};
    tick(1);
    ctrl_wr = 1'b0;
    note(K_EN, 21'h0);
    tick(2);
    note(K_ST, 21'h0);
    repeat (2)
    begin
      startup(8'h1 + {6'h0, lfsr[1:0]});
      lfsr = lfsr_next(lfsr);
      wait_for(1'b1, 800);
      note(K_FRQ, 21'h1);
      clocks_follow();
    end
    // disabling in mid-measurement abandons it and drops every flag
    startup(8'h1 + {6'h0, lfsr[1:0]});
    lfsr = lfsr_next(lfsr);
    tick(300);
    write(1'b0, lfsr);
    note(K_EN, 21'h0);
    note(K_ST, 21'h0);
    note(K_RDY, 21'h0);
    #2;
    wrap_up();
  end

endmodule
